/* File: pab_mux_pkg.sv */
/*
 * constants for the port a / port b alternate function override block.
 * assumes a single clock domain; every input except rst_n is synchronous to ref_clk.
 */
package pab_mux_pkg;
    // ------------------------------------------------------------
    // port widths and pin positions
    // ------------------------------------------------------------
    localparam int PORT_W    = 8;       // pins per port
    localparam int PB_T2_CMP  = 7;      // timer2 / timer1 c compare pin
    localparam int PB_T1B_CMP = 6;      // timer1 compare b pin
    localparam int PB_T1A_CMP = 5;      // timer1 compare a pin
    localparam int PB_T0_CMP  = 4;      // timer0 compare pin
    localparam int PB_MISO   = 3;       // spi master in / slave out
    localparam int PB_MOSI   = 2;       // spi master out / slave in
    localparam int PB_SCK    = 1;       // spi clock
    localparam int PB_SS     = 0;       // spi slave select
    localparam int SPI_W     = 4;       // pins owned by the spi
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PORT_W-1:0] BYTE_RST = 8'h00; // outputs low except pa_oe_n and pb_oe_n, which reset high
    localparam logic [1:0]        SYNC_RST = 2'h0;  // reset sync init
endpackage : pab_mux_pkg

/* File: pab_mux.sv */
/*
 * alternate function override logic for port a (external memory muxed
 * address/data) and port b (timer compare and spi pins).
 * assumes the memory interface, timers and spi live outside and hand in
 * their control and data levels synchronous to ref_clk; the pad cells
 * outside combine the registered enables with the pin levels.
 */
`timescale 1ns/1ps

// Behaviour
// - port a carries muxed address/data byte
// - port a override enables follow memory enable
// - drive during strobe or address; input enable untouched
// - address bits in address phase, data on write
// - pull-up only idle, output one, not disabled
// - pb7 outputs timer2 or timer1 c compare
// - pb6 outputs timer1 compare b
// - pb5 outputs timer1 compare a
// - pb4 outputs timer0 compare and pwm
// - pb3..pb0 are miso, mosi, sck, ss
// - no timer1 c on pb7 in legacy mode
// - spi master overrides pull-up and direction; value stays port bit
module pab_mux
    import pab_mux_pkg::*;
(
    input  wire logic              ref_clk,          // 25 mhz clock
    input  wire logic              rst_n,            // async reset, low
    // port a register bits and memory interface
    input  wire logic [PORT_W-1:0] pa_dir,           // port a direction
    input  wire logic [PORT_W-1:0] port_a_output_bit, // port a out reg
    input  wire logic              global_pullup_disable, // pull-up off
    input  wire logic              ext_mem_enable,   // memory owns port a
    input  wire logic              wr_strobe,        // memory write strobe
    input  wire logic              address_phase_active, // address out
    input  wire logic [PORT_W-1:0] mem_addr_lo,      // low address byte
    input  wire logic [PORT_W-1:0] mem_wdata,        // write data byte
    input  wire logic [PORT_W-1:0] pa_pin_in,        // port a pin levels
    // port b register bits and peripherals
    input  wire logic [PORT_W-1:0] pb_dir,           // port b direction
    input  wire logic [PORT_W-1:0] pb_port,          // port b out reg
    input  wire logic [PORT_W-1:0] pb_pin_in,        // port b pin levels
    input  wire logic              legacy_mode,      // compatibility mode
    input  wire logic              timer2_compare_en, // timer2 owns pb7
    input  wire logic              timer2_compare_out, // timer2 output
    input  wire logic              timer1_c_en,      // timer1 c owns pb7
    input  wire logic              timer1_compare_out_c, // timer1 c out
    input  wire logic              timer1_b_en,      // timer1 b owns pb6
    input  wire logic              timer1_compare_out_b, // timer1 b out
    input  wire logic              timer1_a_en,      // timer1 a owns pb5
    input  wire logic              timer1_compare_out_a, // timer1 a out
    input  wire logic              timer0_en,        // timer0 owns pb4
    input  wire logic              timer0_compare_out, // timer0 output
    input  wire logic              spi_enable_bit,   // spi enabled
    input  wire logic              spi_master_select, // spi is master
    input  wire logic              spi_slave_out,    // slave data out
    input  wire logic              spi_master_out,   // master data out
    input  wire logic              spi_sck_out,      // master clock out
    // port a pad controls
    output logic [PORT_W-1:0]      pa_out,           // pad output value
    output logic [PORT_W-1:0]      pa_oe_n,          // low = pad driven
    output logic [PORT_W-1:0]      pa_pullup,        // pull-up on
    output logic [PORT_W-1:0]      pa_input_en,      // digital input on
    output logic [PORT_W-1:0]      mem_rdata,        // read data to mem
    // port b pad controls
    output logic [PORT_W-1:0]      pb_out,           // pad output value
    output logic [PORT_W-1:0]      pb_oe_n,          // low = pad driven
    output logic [PORT_W-1:0]      pb_pullup,        // pull-up on
    output logic                   spi_miso_in,      // master data in
    output logic                   spi_mosi_in,      // slave data in
    output logic                   spi_sck_in,       // slave clock in
    output logic                   spi_ss_in         // slave select in
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0] pa_out;      // port a value
        logic [PORT_W-1:0] pa_oe_n;     // port a drive enable, low
        logic [PORT_W-1:0] pa_pullup;   // port a pull-up
        logic [PORT_W-1:0] pa_input_en; // port a input enable
        logic [PORT_W-1:0] mem_rdata;   // read data
        logic [PORT_W-1:0] pb_out;      // port b value
        logic [PORT_W-1:0] pb_oe_n;     // port b drive enable, low
        logic [PORT_W-1:0] pb_pullup;   // port b pull-up
        logic [SPI_W-1:0]  spi_in;      // spi pin inputs
    } mux_s;

    logic [1:0]  rst_sync_ff;           // reset release synchroniser
    logic        rst_core_n;            // synchronised reset
    mux_s        st_ff;                 // registered state
    mux_s        nxt_st;                // next state
    logic [PORT_W-1:0] pa_drive;        // port a driver enables
    logic [PORT_W-1:0] pb_drive;        // port b driver enables
    logic [PORT_W-1:0] pb_val_ovr_en;   // port b value override en
    logic [PORT_W-1:0] pb_val_ovr;      // port b value override val
    logic [PORT_W-1:0] pb_pu_ovr_en;    // port b pull-up override en
    logic [PORT_W-1:0] pb_dir_ovr_en;   // port b direction override en
    logic              spi_master;      // spi enabled as master
    logic              pa_bus_drive;    // memory drives port a
    logic              pa_pu_idle;      // pull-up idle term

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // async assert, two-flop synchronous release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= SYNC_RST;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_ff[1];

    // ------------------------------------------------------------
    // override equations
    // ------------------------------------------------------------
    // per-pin control for both ports
    always_comb begin
        nxt_st       = st_ff;
        spi_master   = spi_enable_bit & spi_master_select;
        pa_bus_drive = wr_strobe | address_phase_active;
        pa_pu_idle   = ~pa_bus_drive & ~global_pullup_disable;
        pb_val_ovr_en = '0;
        pb_val_ovr    = '0;
        pb_pu_ovr_en  = '0;
        pb_dir_ovr_en = '0;
        pa_drive     = '0;
        pb_drive     = '0;
        // pb7: timer2 always, timer1 c only outside legacy mode
        if (timer2_compare_en) begin
            pb_val_ovr_en[PB_T2_CMP] = 1'b1;
            pb_val_ovr[PB_T2_CMP]    = timer2_compare_out;
        end else if (timer1_c_en && !legacy_mode) begin
            pb_val_ovr_en[PB_T2_CMP] = 1'b1;
            pb_val_ovr[PB_T2_CMP]    = timer1_compare_out_c;
        end
        pb_val_ovr_en[PB_T1B_CMP] = timer1_b_en;
        pb_val_ovr[PB_T1B_CMP]    = timer1_compare_out_b;
        pb_val_ovr_en[PB_T1A_CMP] = timer1_a_en;
        pb_val_ovr[PB_T1A_CMP]    = timer1_compare_out_a;
        pb_val_ovr_en[PB_T0_CMP]  = timer0_en;
        pb_val_ovr[PB_T0_CMP]     = timer0_compare_out;
        // spi master takes pull-up and direction of its pins; its value override never applies (inputs)
        pb_pu_ovr_en[SPI_W-1:0]  = {SPI_W{spi_master}};
        pb_dir_ovr_en[SPI_W-1:0] = {SPI_W{spi_master}};
        pb_val_ovr_en[PB_MISO]   = spi_master;
        pb_val_ovr[PB_MISO]      = spi_slave_out;
        pb_val_ovr_en[PB_MOSI]   = spi_master;
        pb_val_ovr[PB_MOSI]      = spi_master_out;
        pb_val_ovr_en[PB_SCK]    = spi_master;
        pb_val_ovr[PB_SCK]       = spi_sck_out;
        for (int i = 0; i < PORT_W; i++) begin
            // port a: memory override or plain register control
            if (ext_mem_enable) begin
                pa_drive[i] = pa_bus_drive;
                nxt_st.pa_out[i] =
                    (mem_addr_lo[i] & address_phase_active) |
                    (mem_wdata[i] & wr_strobe);
                nxt_st.pa_pullup[i] =
                    pa_pu_idle & port_a_output_bit[i];
            end else begin
                pa_drive[i] = pa_dir[i];
                nxt_st.pa_out[i] = port_a_output_bit[i];
                nxt_st.pa_pullup[i] = ~pa_dir[i] &
                    port_a_output_bit[i] & ~global_pullup_disable;
            end
            nxt_st.pa_oe_n[i] = ~pa_drive[i];
            // port b: direction override forces driver off (input)
            pb_drive[i] = pb_dir_ovr_en[i] ? 1'b0 : pb_dir[i];
            nxt_st.pb_oe_n[i] = ~pb_drive[i];
            nxt_st.pb_out[i] = (pb_val_ovr_en[i] && pb_drive[i]) ?
                pb_val_ovr[i] : pb_port[i];
            nxt_st.pb_pullup[i] = pb_pu_ovr_en[i] ?
                (pb_port[i] & global_pullup_disable) :
                (~pb_dir[i] & pb_port[i] & ~global_pullup_disable);
        end
        nxt_st.pa_input_en = '1;
        nxt_st.mem_rdata   = pa_pin_in;
        nxt_st.spi_in      = pb_pin_in[SPI_W-1:0];
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_ff <= '{pa_out: BYTE_RST, pa_oe_n: '1, pa_pullup: BYTE_RST,
                       pa_input_en: BYTE_RST, mem_rdata: BYTE_RST,
                       pb_out: BYTE_RST, pb_oe_n: '1,
                       pb_pullup: BYTE_RST, spi_in: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pa_out      = st_ff.pa_out;
    assign pa_oe_n     = st_ff.pa_oe_n;
    assign pa_pullup   = st_ff.pa_pullup;
    assign pa_input_en = st_ff.pa_input_en;
    assign mem_rdata   = st_ff.mem_rdata;
    assign pb_out      = st_ff.pb_out;
    assign pb_oe_n     = st_ff.pb_oe_n;
    assign pb_pullup   = st_ff.pb_pullup;
    assign spi_miso_in = st_ff.spi_in[PB_MISO];
    assign spi_mosi_in = st_ff.spi_in[PB_MOSI];
    assign spi_sck_in  = st_ff.spi_in[PB_SCK];
    assign spi_ss_in   = st_ff.spi_in[PB_SS];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_addr_cycle;
        ext_mem_enable && address_phase_active && !wr_strobe;
    endsequence
    sequence s_addr_out;
        !pa_oe_n[0] && pa_out == $past(mem_addr_lo);
    endsequence

    a_addr_phase_out: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n) s_addr_cycle |=> s_addr_out)
        else $error("address byte not driven in address phase");
    a_write_data_out: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        ext_mem_enable && wr_strobe && !address_phase_active
        |=> pa_out == $past(mem_wdata) && pa_oe_n == 8'h00)
        else $error("write data not driven during strobe");
    a_mem_idle_input: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        ext_mem_enable && !wr_strobe && !address_phase_active
        |=> pa_oe_n == 8'hff)
        else $error("port a driven while memory idle");
    a_input_en_kept: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        $past(rst_core_n) |-> pa_input_en == 8'hff)
        else $error("port a input enable overridden");
    a_pullup_idle: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        ext_mem_enable && (wr_strobe || global_pullup_disable)
        |=> pa_pullup == 8'h00)
        else $error("port a pull-up on during strobe or disable");
    a_plain_port_a: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        !ext_mem_enable |=> pa_oe_n == ~$past(pa_dir)
        && pa_out == $past(port_a_output_bit))
        else $error("port a not under register control");
    a_legacy_no_t1c: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        legacy_mode && !timer2_compare_en && !spi_master
        |=> pb_out[7] == $past(pb_port[7]))
        else $error("timer1 c reached pb7 in legacy mode");
    a_t1b_out: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        timer1_b_en && pb_dir[6] |=> pb_out[6] == $past(timer1_compare_out_b))
        else $error("timer1 b compare not on pb6");
    a_spi_master_sck: assert property (@(posedge ref_clk)
        disable iff (!rst_core_n)
        spi_master |=> pb_oe_n[PB_SCK]
        && pb_out[PB_SCK] == $past(pb_port[PB_SCK])
        && pb_pullup[PB_SCK] ==
           $past(pb_port[PB_SCK] & global_pullup_disable))
        else $error("spi master override wrong on sck pin");

endmodule : pab_mux

/* File: ext_mem_model.sv */
/* behavioural parallel memory on the muxed port a address/data bus.
   assumes the block's registered pad value and enable on ref_clk. */
`timescale 1ns/1ps
module ext_mem_model
    import pab_mux_pkg::*;
#(
    parameter int RD_HOLD = 2 // cycles a read byte stays on the bus
)(
    input  wire logic              ref_clk,  // bus clock
    input  wire logic [PORT_W-1:0] pa_out,   // value the block drives
    input  wire logic [PORT_W-1:0] pa_oe_n,  // low = block drives
    output logic      [PORT_W-1:0] pa_pin_in // resolved pad level
);
    // ------------------------------------------------------------
    // storage and bus history
    // ------------------------------------------------------------
    logic [PORT_W-1:0] mem [0:255];      // memory array
    logic [PORT_W-1:0] addr_ff, last_ff; // latched address, last level
    logic              drv_ff, drv2_ff;  // driven one and two ago
    int                rd_ff = 0;        // read window left
    logic              drv;              // block drives whole bus
    assign drv = (pa_oe_n == 8'h00);
    // first driven cycle is the address, a second one is write data
    always_ff @(posedge ref_clk) begin
        drv_ff  <= drv;
        drv2_ff <= drv_ff;
        last_ff <= pa_pin_in;
        if (drv && !drv_ff) begin
            addr_ff <= pa_out;
        end else if (drv) begin
            mem[addr_ff] <= pa_out;
        end
        if (!drv && drv_ff && !drv2_ff) begin
            rd_ff <= RD_HOLD; // address alone: answer a read
        end else if (rd_ff > 0) begin
            rd_ff <= rd_ff - 1;
        end
    end
    // block's enabled bits win; a released idle bus keeps changing
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (!pa_oe_n[i]) pa_pin_in[i] = pa_out[i];
            else if (rd_ff > 0) pa_pin_in[i] = mem[addr_ff][i];
            else pa_pin_in[i] = ~last_ff[i];
        end
    end
endmodule : ext_mem_model

/* File: pab_mux_tb.sv */
/* self-checking bench for pab_mux: drives inputs at the falling edge
   and checks the registered pad controls one cycle later.
   assumes pab_mux_pkg, pab_mux and ext_mem_model are compiled first. */
`timescale 1ns/1ps
module pab_mux_tb
    import pab_mux_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0, rst_n = 1'b0; // clock, reset
    logic [7:0] pa_dir, port_a_output_bit, mem_addr_lo, mem_wdata, pa_pin_in;
    logic [7:0] pb_dir, pb_port, pb_pin_in, pa_out, pa_oe_n, pa_pullup;
    logic [7:0] pa_input_en, mem_rdata, pb_out, pb_oe_n, pb_pullup;
    logic global_pullup_disable, ext_mem_enable, wr_strobe, legacy_mode;
    logic address_phase_active, timer2_compare_en, timer2_compare_out;
    logic timer1_c_en, timer1_compare_out_c, timer1_b_en, timer0_en;
    logic timer1_compare_out_b, timer1_a_en, timer1_compare_out_a;
    logic timer0_compare_out, spi_enable_bit, spi_master_select;
    logic spi_slave_out, spi_master_out, spi_sck_out, spi_miso_in;
    logic spi_mosi_in, spi_sck_in, spi_ss_in;
    int   errors = 0, checked = 0;
    logic [4:0] p7 [4] = '{5'h1c, 5'h06, 5'h07, 5'h16}; // pb7 cases
    always #20 ref_clk = ~ref_clk; // 25 mhz
    pab_mux dut (.ref_clk(ref_clk), .rst_n(rst_n), .pa_dir(pa_dir),
        .port_a_output_bit(port_a_output_bit), .mem_addr_lo(mem_addr_lo),
        .global_pullup_disable(global_pullup_disable), .pb_dir(pb_dir),
        .ext_mem_enable(ext_mem_enable), .wr_strobe(wr_strobe),
        .address_phase_active(address_phase_active), .pb_port(pb_port),
        .mem_wdata(mem_wdata), .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in),
        .legacy_mode(legacy_mode), .timer2_compare_en(timer2_compare_en),
        .timer2_compare_out(timer2_compare_out), .timer1_c_en(timer1_c_en),
        .timer1_compare_out_c(timer1_compare_out_c), .timer0_en(timer0_en),
        .timer1_b_en(timer1_b_en), .timer1_compare_out_b(timer1_compare_out_b),
        .timer1_a_en(timer1_a_en), .timer1_compare_out_a(timer1_compare_out_a),
        .timer0_compare_out(timer0_compare_out), .spi_sck_out(spi_sck_out),
        .spi_enable_bit(spi_enable_bit), .spi_master_select(spi_master_select),
        .spi_slave_out(spi_slave_out), .spi_master_out(spi_master_out),
        .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_pullup(pa_pullup),
        .pa_input_en(pa_input_en), .mem_rdata(mem_rdata), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pb_pullup(pb_pullup), .spi_miso_in(spi_miso_in),
        .spi_mosi_in(spi_mosi_in), .spi_sck_in(spi_sck_in),
        .spi_ss_in(spi_ss_in));
    ext_mem_model mem (.ref_clk(ref_clk), .pa_out(pa_out),
        .pa_oe_n(pa_oe_n), .pa_pin_in(pa_pin_in));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic idle(); // every bench input low
        {pa_dir, port_a_output_bit, mem_addr_lo, mem_wdata} = '0;
        {pb_dir, pb_port, pb_pin_in, spi_enable_bit, spi_master_select} = '0;
        {global_pullup_disable, ext_mem_enable, wr_strobe, legacy_mode} = '0;
        {address_phase_active, timer2_compare_en, timer2_compare_out} = '0;
        {timer1_c_en, timer1_compare_out_c, timer1_b_en, timer0_en} = '0;
        {timer1_compare_out_b, timer1_a_en, timer1_compare_out_a} = '0;
        {timer0_compare_out, spi_slave_out, spi_master_out, spi_sck_out} = '0;
    endtask : idle
    task automatic step(int n); // advance to a later falling edge
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic test_done(); // verdict and end of run
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        idle();
        step(4);
        rst_n = 1'b1;
        step(4);
        pa_dir = 8'h0f; // plain port a control
        port_a_output_bit = 8'h96;
        step(1);
        chk("pa_oe_n", 8'hf0, pa_oe_n);
        chk("pa_out", 8'h06, pa_out & 8'h0f);
        chk("pa_pullup", 8'h90, pa_pullup);
        chk("pa_input_en", 8'hff, pa_input_en);
        pa_dir = 8'hff; // memory takes the pins despite direction
        port_a_output_bit = 8'ha5;
        ext_mem_enable = 1'b1;
        address_phase_active = 1'b1;
        mem_addr_lo = 8'h5a;
        step(1);
        chk("pa_out", 8'h5a, pa_out);
        chk("pa_oe_n", 8'h00, pa_oe_n);
        chk("pa_pullup", 8'h00, pa_pullup);
        address_phase_active = 1'b0; // write strobe straight after
        wr_strobe = 1'b1;
        mem_wdata = 8'h3c;
        step(1);
        chk("pa_out", 8'h3c, pa_out);
        chk("pa_oe_n", 8'h00, pa_oe_n);
        wr_strobe = 1'b0;
        step(1);
        chk("pa_oe_n", 8'hff, pa_oe_n);
        chk("pa_pullup", 8'ha5, pa_pullup);
        chk("pa_input_en", 8'hff, pa_input_en);
        address_phase_active = 1'b1; // read back the written byte
        global_pullup_disable = 1'b1;
        step(1);
        address_phase_active = 1'b0;
        step(3);
        chk("mem_rdata", 8'h3c, mem_rdata);
        chk("pa_pullup", 8'h00, pa_pullup);
        ext_mem_enable = 1'b0;
        step(1);
        chk("pa_oe_n", 8'h00, pa_oe_n);
        pb_dir = 8'hff; // pb7 owner table, port bit low
        for (int i = 0; i < 4; i++) begin
            {timer2_compare_en, timer2_compare_out, timer1_c_en,
             timer1_compare_out_c, legacy_mode} = p7[i];
            step(1);
            chk("pb_out7", {7'h0, i < 2}, {7'h0, pb_out[7]});
        end
        {timer1_b_en, timer1_compare_out_b, timer1_a_en} = 3'h7;
        {timer1_compare_out_a, timer0_en, timer0_compare_out} = 3'h3;
        pb_port = 8'h20;
        step(1);
        chk("pb_out", 8'h50, pb_out & 8'h70);
        global_pullup_disable = 1'b0; // pull-ups allowed again
        pb_dir = 8'h0f;
        step(1);
        chk("pb_oe_n", 8'hf0, pb_oe_n);
        chk("pb_pullup", 8'h20, pb_pullup);
        pb_port = 8'h0f; // spi master forces inputs
        pb_pin_in = 8'h0a;
        spi_enable_bit = 1'b1;
        spi_master_select = 1'b1;
        global_pullup_disable = 1'b1; // override pull-up follows the bit
        step(1);
        chk("pb_oe_n", 8'hff, pb_oe_n);
        chk("pb_out", 8'h0f, pb_out);
        chk("pb_pullup", 8'h0f, pb_pullup);
        chk("spi_in", 8'h0a, {4'h0, spi_miso_in, spi_mosi_in,
            spi_sck_in, spi_ss_in});
        spi_master_select = 1'b0;
        pb_pin_in = 8'h05;
        step(1);
        chk("pb_oe_n", 8'hf0, pb_oe_n);
        chk("pb_pullup", 8'h00, pb_pullup);
        chk("spi_in", 8'h05, {4'h0, spi_miso_in, spi_mosi_in,
            spi_sck_in, spi_ss_in});
        test_done();
    end
    // tests need under 60 cycles; 2000 means a hang
    initial begin
        repeat (2000) @(posedge ref_clk);
        errors++;
        test_done();
    end
endmodule : pab_mux_tb
